// [lgt_regs.vh]
// Register offsets, field positions and decode codes for the line-side gain/termination bank
`ifndef LGT_REGS_VH
`define LGT_REGS_VH
`define LGT_OFF_REVISION     8'h34
`define LGT_OFF_RESERVED     8'h38
`define LGT_OFF_GAIN         8'h3c
`define LGT_OFF_LINE         8'h40
`define LGT_IDX_REVISION     8'h0d
`define LGT_IDX_RESERVED     8'h0e
`define LGT_IDX_GAIN         8'h0f
`define LGT_IDX_LINE         8'h10
`define LGT_REV_ONE_BIT      6
`define LGT_REV_FIELD_LSB    2
`define LGT_TXM_BIT          7
`define LGT_ATX_LSB          4
`define LGT_RXM_BIT          3
`define LGT_ARX_LSB          0
`define LGT_TERMINATION_SEL_HI_BIT         7
`define LGT_OHS_BIT          6
`define LGT_ACT_BIT          5
`define LGT_IIR_BIT          4
`define LGT_RZ_BIT           1
`define LGT_RT_BIT           0
`define LGT_GAIN_RESET       8'h00
`define LGT_LINE_RESET       8'h00
`define LGT_LINE_WMASK       8'hf3
`define LGT_TERM_REAL600     2'h0
`define LGT_TERM_GLOBAL      2'h1
`define LGT_TERM_TBR21       2'h2
`define LGT_TERM_NZ          2'h3
`define LGT_SPEED_FAST       2'h0
`define LGT_SPEED_3MS        2'h1
`define LGT_SPEED_26MS       2'h2
`define LGT_VAR_SINGLE       2'h0
`define LGT_VAR_FOUR         2'h1
`define LGT_VAR_REDUCED      2'h2
`define LGT_STEP_MAX         3'h4
`endif

// [lgt_step_decode.v]
// Three-bit gain or attenuation code to 3 dB step count
`timescale 1ns/10ps
module lgt_step_decode (
  input  wire [2:0] code,
  output wire [2:0] steps
);
  `include "lgt_regs.vh"
  // Any code with the top bit set means the full 12 dB step
  assign steps = code[2] ? `LGT_STEP_MAX : code; // R04
endmodule

// [lgt_line_regs.v]
// APB register bank for line-side revision, gain and line interface control
//
// Functional notes
// R01: The revision register always reads one in bit 6.
// R02: Bits 5:2 of the revision register show a read-only four-bit line-side revision.
// R03: Gain bit 7 mutes the transmit path while set.
// R04: Attenuation bits 6:4 and gain bits 2:0 decode to 0/3/6/9 dB, and 12 dB for 1xx.
// R05: Gain bit 3 mutes the receive path while set.
// R06: On the four-termination variant bits 7,5 pick 600 ohm, global, TBR21 or NZ.
// R07: Reduced variant maps 00/11 to 600 ohm and 01/10 to TBR21; single variant is 600 ohm.
// R08: Bit 6 with the companion bit picks under 0.5 ms, 3 ms or 26 ms hangup; bit 6 wins.
// R09: Bit 4 picks FIR (0) or IIR (1) filters, honoured only with the 32.768 MHz module.
// R10: Bit 1 picks synthesized ringer impedance on capable variants, else maximum.
// R11: Bit 0 picks the upper ring threshold window; some variants force the lower one.
// R12: Ring detect never fires below the window's lower level and always above its upper.
// R13: Reserved bits and the reserved register read zero and ignore writes.
//
// The implementer's own choice: the APB register port.
`timescale 1ns/10ps
module lgt_line_regs #(
  parameter [1:0]  TERM_VARIANT    = 2'h1,
  parameter        RINGER_CAPABLE  = 1,
  parameter        THRESH_CAPABLE  = 1,
  parameter [3:0]  LINE_REVISION   = 4'h0,   // Arbitrary value
  parameter [15:0] RING_LOW_LO     = 16'h0087, // Threshold codes, tenths of Vrms
  parameter [15:0] RING_LOW_HI     = 16'h00a5,
  parameter [15:0] RING_HIGH_LO    = 16'h00c2,
  parameter [15:0] RING_HIGH_HI    = 16'h00ed
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  input  wire [3:0]  pstrb,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        hangup_speed_companion,
  input  wire        fast_module_present,
  input  wire [15:0] ring_level,
  output reg         transmit_silence,
  output reg         receive_silence,
  output reg  [2:0]  transmit_atten_steps,
  output reg  [2:0]  receive_gain_steps,
  output reg  [1:0]  termination_mode,
  output reg  [1:0]  hangup_speed_mode,
  output reg         recursive_filter_on,
  output reg         ringer_synth_on,
  output reg         ring_detected
);
  `include "lgt_regs.vh"

  // Storage
  reg  [7:0]  gain_ctrl;
  reg  [7:0]  line_ctrl;
  reg  [1:0]  companion_sync;
  reg  [1:0]  fast_sync;
  reg  [15:0] level_meta;
  reg  [15:0] level_sync;
  reg         ring_state;

  // Decode helpers
  wire        wr_en;
  wire        rd_en;
  wire        addr_hit;
  wire [2:0]  atx_steps;
  wire [2:0]  arx_steps;
  wire        termination_sel_hi;
  wire        termination_sel_lo;
  wire        hangup_speed_sel;
  wire        ring_threshold_eff;
  wire [15:0] win_lo;
  wire [15:0] win_hi;
  wire [7:0]  revision_value;
  reg  [7:0]  next_rdata;
  reg  [1:0]  next_term;
  reg  [1:0]  next_speed;
  reg         next_ring;

  // Zero-wait slave: ready stands high from a flop, so the first access cycle answers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      pready <= 1'b1;
    else
      pready <= 1'b1;
  end

  assign wr_en    = psel & penable & pwrite;
  assign rd_en    = psel & ~penable & ~pwrite;
  assign addr_hit = (paddr == `LGT_OFF_REVISION) | (paddr == `LGT_OFF_RESERVED) |
                    (paddr == `LGT_OFF_GAIN) | (paddr == `LGT_OFF_LINE);

  // Revision word: fixed one above a read-only field
  assign revision_value = (8'h01 << `LGT_REV_ONE_BIT) |         // R01
                          ({4'h0, LINE_REVISION} << `LGT_REV_FIELD_LSB); // R02

  // Register writes, only the low byte lane holds data
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gain_ctrl <= `LGT_GAIN_RESET;
      line_ctrl <= `LGT_LINE_RESET;
    end else if (wr_en && pstrb[0]) begin
      if (paddr == `LGT_OFF_GAIN)
        gain_ctrl <= pwdata[7:0];
      if (paddr == `LGT_OFF_LINE)
        line_ctrl <= pwdata[7:0] & `LGT_LINE_WMASK; // R13
    end
  end

  // Read mux; revision and reserved slot ignore writes
  always @* begin
    case (paddr)
      `LGT_OFF_REVISION: next_rdata = revision_value; // R01
      `LGT_OFF_RESERVED: next_rdata = 8'h00;          // R13
      `LGT_OFF_GAIN:     next_rdata = gain_ctrl;
      `LGT_OFF_LINE:     next_rdata = line_ctrl;
      default:           next_rdata = 8'h00;
    endcase
  end

  // Read data captured in setup so it is valid for the access edge
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      if (rd_en)
        prdata <= {24'h00_0000, next_rdata}; // R13
      if (psel && !penable)
        pslverr <= ~addr_hit;
      else if (!psel)
        pslverr <= 1'b0;
    end
  end

  // Step decoders for both analog paths
  lgt_step_decode u_atx (
    .code  (gain_ctrl[`LGT_ATX_LSB+2:`LGT_ATX_LSB]),
    .steps (atx_steps)
  );
  lgt_step_decode u_arx (
    .code  (gain_ctrl[`LGT_ARX_LSB+2:`LGT_ARX_LSB]),
    .steps (arx_steps)
  );

  // Pins from the line side are two-flop synchronised
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      companion_sync <= 2'b00;
      fast_sync      <= 2'b00;
      level_meta     <= 16'h0000;
      level_sync     <= 16'h0000;
    end else begin
      companion_sync <= {companion_sync[0], hangup_speed_companion};
      fast_sync      <= {fast_sync[0], fast_module_present};
      level_meta     <= ring_level;
      level_sync     <= level_meta;
    end
  end

  assign termination_sel_hi = line_ctrl[`LGT_TERMINATION_SEL_HI_BIT];
  assign termination_sel_lo = line_ctrl[`LGT_ACT_BIT];
  assign hangup_speed_sel   = line_ctrl[`LGT_OHS_BIT];

  // Termination decode per variant
  always @* begin
    case (TERM_VARIANT)
      `LGT_VAR_FOUR:
        next_term = {termination_sel_hi, termination_sel_lo}; // R06
      `LGT_VAR_REDUCED:
        next_term = (termination_sel_hi ^ termination_sel_lo) ?
                    `LGT_TERM_TBR21 : `LGT_TERM_REAL600; // R07
      default:
        next_term = `LGT_TERM_REAL600; // R07
    endcase
  end

  // Hangup speed: the local bit overrides the companion
  always @* begin
    if (hangup_speed_sel)
      next_speed = `LGT_SPEED_26MS; // R08
    else if (companion_sync[1])
      next_speed = `LGT_SPEED_3MS; // R08
    else
      next_speed = `LGT_SPEED_FAST; // R08
  end

  // Threshold window; forced low on variants without the option
  assign ring_threshold_eff = THRESH_CAPABLE ? line_ctrl[`LGT_RT_BIT] : 1'b0; // R11
  assign win_lo = ring_threshold_eff ? RING_HIGH_LO : RING_LOW_LO; // R11
  assign win_hi = ring_threshold_eff ? RING_HIGH_HI : RING_LOW_HI; // R11

  // Hysteresis inside the window keeps the detector from chattering
  always @* begin
    if (level_sync < win_lo)
      next_ring = 1'b0; // R12
    else if (level_sync > win_hi)
      next_ring = 1'b1; // R12
    else
      next_ring = ring_state;
  end

  // Registered outputs to the analog side
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      transmit_silence     <= 1'b0;
      receive_silence      <= 1'b0;
      transmit_atten_steps <= 3'h0;
      receive_gain_steps   <= 3'h0;
      termination_mode     <= `LGT_TERM_REAL600;
      hangup_speed_mode    <= `LGT_SPEED_FAST;
      recursive_filter_on  <= 1'b0;
      ringer_synth_on      <= 1'b0;
      ring_state           <= 1'b0;
      ring_detected        <= 1'b0;
    end else begin
      transmit_silence     <= gain_ctrl[`LGT_TXM_BIT]; // R03
      receive_silence      <= gain_ctrl[`LGT_RXM_BIT]; // R05
      transmit_atten_steps <= atx_steps; // R04
      receive_gain_steps   <= arx_steps; // R04
      termination_mode     <= next_term;
      hangup_speed_mode    <= next_speed;
      // Older system modules only have FIR filters
      recursive_filter_on  <= line_ctrl[`LGT_IIR_BIT] & fast_sync[1]; // R09
      ringer_synth_on      <= (RINGER_CAPABLE != 0) & line_ctrl[`LGT_RZ_BIT]; // R10
      ring_state           <= next_ring;
      ring_detected        <= next_ring; // R12
    end
  end
endmodule

// [lgt_checker.sv]
// Concurrent checks on the line-side gain and termination register bank
`timescale 1ns/10ps
module lgt_checker (
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [7:0]  paddr,
  input wire [31:0] pwdata,
  input wire [3:0]  pstrb,
  input wire [31:0] prdata,
  input wire [15:0] ring_level,
  input wire        transmit_silence,
  input wire        receive_silence,
  input wire [2:0]  transmit_atten_steps,
  input wire [2:0]  receive_gain_steps,
  input wire [1:0]  termination_mode,
  input wire [1:0]  hangup_speed_mode,
  input wire        ringer_synth_on,
  input wire        ring_detected
);
  // Access-phase decodes
  wire       wr   = psel && penable && pwrite && pstrb[0];
  wire       rd   = psel && penable && !pwrite;
  wire       wr_g = wr && paddr == 8'h3c;
  wire       wr_l = wr && paddr == 8'h40;
  reg  [7:0] gw;
  reg  [7:0] lw;
  // Last written bytes; outputs follow two edges later
  always @(posedge pclk) begin
    if (wr_g) gw <= pwdata[7:0];
    if (wr_l) lw <= pwdata[7:0];
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_rev_fixed_one: assert property (rd && paddr == 8'h34 |-> prdata[31:6] == 26'h1
    && prdata[1:0] == 2'h0) else $error("revision read wrong");
  a_rsvd_reads_zero: assert property (rd && paddr == 8'h38 |-> prdata == 32'h0)
    else $error("reserved read not zero");
  a_tx_mute: assert property (wr_g |-> ##2 transmit_silence == gw[7])
    else $error("tx mute wrong");
  a_rx_mute: assert property (wr_g |-> ##2 receive_silence == gw[3])
    else $error("rx mute wrong");
  a_tx_steps: assert property (wr_g |-> ##2
    transmit_atten_steps == (gw[6] ? 3'h4 : {1'b0, gw[5:4]})) else $error("tx steps wrong");
  a_rx_steps: assert property (wr_g |-> ##2
    receive_gain_steps == (gw[2] ? 3'h4 : {1'b0, gw[1:0]})) else $error("rx steps wrong");
  a_term_code: assert property (wr_l |-> ##2 termination_mode == {lw[7], lw[5]})
    else $error("termination wrong");
  a_speed_bit_wins: assert property (wr_l && pwdata[6] |-> ##2 hangup_speed_mode == 2'h2)
    else $error("speed not slowest");
  a_ringer_imp: assert property (wr_l |-> ##2 ringer_synth_on == lw[1])
    else $error("ringer impedance wrong");
  a_ring_below: assert property ((ring_level < 16'h0087) [*4] |-> !ring_detected)
    else $error("ring below window");
  a_ring_above: assert property ((ring_level > 16'h00ed) [*4] |-> ring_detected)
    else $error("ring above window missed");
  c_gain_wr: cover property (wr_g);
  c_speed_wr: cover property (wr_l && pwdata[6]);
  c_ring_up: cover property ($rose(ring_detected));
endmodule
bind lgt_line_regs lgt_checker chk (.*);

// [testbench.sv]
// Self-checking bench for the line-side gain and termination register bank
`timescale 1ns/10ps
module testbench;
  reg         pclk, presetn, psel, penable, pwrite, comp, fmp, err;
  reg  [7:0]  paddr, v;
  reg  [31:0] pwdata, rd;
  reg  [3:0]  pstrb;
  reg  [15:0] ring_level;
  wire [31:0] prdata;
  wire        pready, pslverr, tx_m, rx_m, filt, synth, ring;
  wire [2:0]  tx_s, rx_s;
  wire [1:0]  term, speed;
  integer     n_fail = 0, checks = 0, i;
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_fail++; \
  $display("[ERR] %0t got %h want %h", $time, a, b); end end
  lgt_line_regs dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .hangup_speed_companion(comp),
    .fast_module_present(fmp), .ring_level(ring_level), .transmit_silence(tx_m),
    .receive_silence(rx_m), .transmit_atten_steps(tx_s), .receive_gain_steps(rx_s),
    .termination_mode(term), .hangup_speed_mode(speed), .recursive_filter_on(filt),
    .ringer_synth_on(synth), .ring_detected(ring));
  // One APB transfer, held until pready is seen at an edge
  task apb(input w, input [7:0] a, input [7:0] d);
    begin
      @(posedge pclk);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= {24'h00_0000, d};
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd  = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task t_rev;
    begin
      apb(1, 8'h34, 8'hff);
      apb(0, 8'h34, 8'h00);
      `CHK(rd, 32'h0000_0040)
      `CHK(err, 1'b0)
      `CHK(pready, 1'b1)
      apb(1, 8'h38, 8'hff);
      apb(0, 8'h38, 8'h00);
      `CHK(rd, 32'h0000_0000)
      apb(0, 8'h44, 8'h00);
      `CHK(err, 1'b1)
      $display("t_rev done");
    end
  endtask
  task t_gain;
    begin
    for (i = 0; i < 8; i++) begin
      v = {i[0], i[2:0], ~i[0], i[2:0]};
      apb(1, 8'h3c, v);
      apb(0, 8'h3c, 8'h00);
      #1;
      `CHK(rd[7:0], v)
      `CHK(tx_m, v[7])
      `CHK(rx_m, v[3])
      `CHK(tx_s, v[6] ? 3'h4 : {1'b0, v[5:4]})
      `CHK(rx_s, v[2] ? 3'h4 : {1'b0, v[1:0]})
    end
    $display("t_gain done");
    end
  endtask
  task t_line;
    begin
      // Bits 3:2 are set on purpose to see them masked
      for (i = 0; i < 4; i++) begin
        v = {i[1], 1'b0, i[0], 1'b1, 2'b11, i[0], i[1]};
        apb(1, 8'h40, v);
        apb(0, 8'h40, 8'h00);
        #1;
        `CHK(rd[7:0], v & 8'hf3)
        `CHK(term, i[1:0])
        `CHK(filt, 1'b1)
        `CHK(synth, i[0])
      end
      @(posedge pclk);
      fmp <= 1'b0;
      repeat (5) @(posedge pclk);
      #1;
      `CHK(filt, 1'b0)
      $display("t_line done");
    end
  endtask
  task t_speed;
    begin
    for (i = 0; i < 4; i++) begin
      @(posedge pclk);
      comp <= i[0];
      apb(1, 8'h40, {1'b0, i[1], 6'h00});
      repeat (4) @(posedge pclk);
      #1;
      `CHK(speed, i[1] ? 2'h2 : {1'b0, i[0]})
    end
    $display("t_speed done");
    end
  endtask
  // Level held long enough to cross the input synchroniser
  task lvl(input [15:0] l, input x);
    begin
      @(posedge pclk);
      ring_level <= l;
      repeat (5) @(posedge pclk);
      #1;
      `CHK(ring, x)
    end
  endtask
  task t_ring;
    begin
      apb(1, 8'h40, 8'h00);
      lvl(16'h0064, 1'b0);
      lvl(16'h00b4, 1'b1);
      apb(1, 8'h40, 8'h01);
      lvl(16'h012c, 1'b1);
      lvl(16'h00b4, 1'b0);
      $display("t_ring done");
    end
  endtask
  task end_sim;
    begin
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) begin
        $display("ALL CHECKS OK");
      end else begin
        $display("CHECKS NOT OK");
      end
      $finish;
    end
  endtask
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // Watchdog well beyond the under two hundred cycles the tests need
  initial begin
    #50000;
    n_fail++;
    end_sim;
  end
  initial begin
    {presetn, psel, penable, pwrite, comp, paddr, pwdata, ring_level} = 0;
    pstrb = 4'hf;
    fmp   = 1'b1;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_rev;
    t_gain;
    t_line;
    t_speed;
    t_ring;
    end_sim;
  end
endmodule
